// ==== hw/ldc_pkg.sv ====
// Package of register offsets, field positions, reset values and timing counts for the LED driver control block.
`default_nettype none
package ldc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] LDC_ADDR_CONFIG = 8'h07;
  localparam logic [7:0] LDC_ADDR_LEVEL = 8'h08;
  // ==========================================================================
  // Configuration fields
  localparam int LDC_CFG_MODE_HI = 6;
  localparam int LDC_CFG_MODE_LO = 5;
  localparam int LDC_CFG_SLOW_EDGE = 4;
  localparam int LDC_CFG_DOUBLE_FS = 3;
  localparam int LDC_CFG_STEP_HI = 2;
  localparam logic [7:0] LDC_CONFIG_RESET = 8'h0f;
  localparam logic [7:0] LDC_CONFIG_WMASK = 8'h7f;
  localparam logic [7:0] LDC_LEVEL_RESET = 8'h00;
  localparam logic [1:0] LDC_MODE_BOTH = 2'h0;
  localparam logic [1:0] LDC_MODE_FIRST = 2'h1;
  localparam logic [1:0] LDC_MODE_HV_BOOST = 2'h2;
  localparam logic [1:0] LDC_MODE_EXT_SUPPLY = 2'h3;
  // ==========================================================================
  // Gradation timing
  localparam int LDC_CLK_HZ = 10_000_000;
  localparam int LDC_STEP0_NS = 56_000;
  localparam int LDC_STEP1_NS = 912_000;
  localparam int LDC_STEP7_NS = 58_368_000;
  localparam int LDC_STEP0_CYC = LDC_STEP0_NS / (1_000_000_000 / LDC_CLK_HZ);
  localparam int LDC_STEP1_CYC = LDC_STEP1_NS / (1_000_000_000 / LDC_CLK_HZ);
  localparam int LDC_STEP7_CYC = LDC_STEP7_NS / (1_000_000_000 / LDC_CLK_HZ);
endpackage
`default_nettype wire

// ==== hw/ldc_step_if.sv ====
// Interface joining the ramp engine to its step-time divider.
`default_nettype none
interface ldc_step_if;
  logic [2:0] code;
  logic tick;
  modport owner (output code, input tick);
  modport timer (input code, output tick);
endinterface
`default_nettype wire

// ==== hw/ldc_step_timer.sv ====
// Divider that issues one enable pulse per gradation step interval.
`default_nettype none
module ldc_step_timer #(
  parameter int STEP0_CYC = ldc_pkg::LDC_STEP0_CYC,
  parameter int STEP1_CYC = ldc_pkg::LDC_STEP1_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  ldc_step_if.timer step
);
  localparam int CW = 24;
  // The longest interval is the code-1 count shifted left by six, and it must fit the counter.
  if (STEP0_CYC < 1 || STEP1_CYC < 1 || (STEP1_CYC * 128) >= (1 << CW)) begin : g_bad_counts
    $error("ldc_step_timer: step counts out of range");
  end
  // ==========================================================================
  // Interval decode
  function automatic logic [CW-1:0] ldc_interval(input logic [2:0] code);
    if (code == 3'h0) begin
      return CW'(STEP0_CYC);
    end
    return CW'(STEP1_CYC) << (code - 3'h1);
  endfunction
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    cnt_nxt = cnt_r + CW'(1);
    tick_nxt = 1'b0;
    if (cnt_r >= ldc_interval(step.code) - CW'(1)) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign step.tick = tick_r;
endmodule // ldc_step_timer
`default_nettype wire

// ==== hw/ldc_regs.sv ====
// Register bank and current gradation engine of the LED driver control block.
`default_nettype none
module ldc_regs #(
  parameter int STEP0_CYC = ldc_pkg::LDC_STEP0_CYC,
  parameter int STEP1_CYC = ldc_pkg::LDC_STEP1_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic led_enable_out,
  output logic first_string_out,
  output logic second_string_out,
  output logic hv_boost_out,
  output logic boost_power_out,
  output logic slow_edge_out,
  output logic double_full_scale_out,
  output logic [7:0] applied_level_out,
  output logic ramp_busy_out
);
  // ==========================================================================
  // Parameter check
  // A one-cycle step would move the applied level on back-to-back edges.
  // The busy flag and the one-step-per-interval promise cannot follow that, so it is refused.
  if (STEP0_CYC < 2 || STEP1_CYC < 2) begin : g_bad_step
    $error("ldc_regs: step counts below two cycles are not supported");
  end
  // ==========================================================================
  // Decode helpers
  function automatic logic ldc_is_boost(input logic [1:0] mode_sel);
    return mode_sel == ldc_pkg::LDC_MODE_HV_BOOST;
  endfunction
  // ==========================================================================
  // Step timer
  // The divider free-runs, so the first step after a rewrite may come up to one interval late.
  // That costs one interval of latency and saves a restart path on every write.
  ldc_step_if step_bus();
  ldc_step_timer #(.STEP0_CYC(STEP0_CYC), .STEP1_CYC(STEP1_CYC)) u_timer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .step(step_bus)
  );
  // ==========================================================================
  // Write path
  // Bit 7 is masked on entry, so it can never steer anything and reads back as zero.
  logic [7:0] config_r;
  logic [7:0] config_nxt;
  logic [7:0] level_r;
  logic [7:0] level_nxt;
  always_comb begin
    config_nxt = config_r;
    level_nxt = level_r;
    if (wr_en_in && addr_in == ldc_pkg::LDC_ADDR_CONFIG) begin
      config_nxt = wdata_in & ldc_pkg::LDC_CONFIG_WMASK;
    end
    if (wr_en_in && addr_in == ldc_pkg::LDC_ADDR_LEVEL) begin
      level_nxt = wdata_in;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_r <= ldc_pkg::LDC_CONFIG_RESET;
      level_r <= ldc_pkg::LDC_LEVEL_RESET;
    end else begin
      config_r <= config_nxt;
      level_r <= level_nxt;
    end
  end
  assign step_bus.code = config_r[ldc_pkg::LDC_CFG_STEP_HI:0];
  // ==========================================================================
  // Read path
  // A read in the same cycle as a write to the same byte returns the old value.
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  always_comb begin
    rvalid_nxt = rd_en_in;
    rdata_nxt = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        ldc_pkg::LDC_ADDR_CONFIG: rdata_nxt = config_r;
        ldc_pkg::LDC_ADDR_LEVEL: rdata_nxt = level_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
  // ==========================================================================
  // Gradation
  // The ramp moves only on a timer tick, so a rewrite in mid-ramp turns it around at the next step.
  logic [1:0] mode;
  logic [7:0] target;
  logic [7:0] applied_r;
  logic [7:0] applied_nxt;
  logic busy_r;
  logic busy_nxt;
  always_comb begin
    mode = config_r[ldc_pkg::LDC_CFG_MODE_HI:ldc_pkg::LDC_CFG_MODE_LO];
    // Boost mode uses the feedback pin, so the target is forced to zero and the level ramps down to it.
    target = ldc_is_boost(mode) ? 8'h00 : level_r;
    applied_nxt = applied_r;
    if (step_bus.tick && applied_r < target) begin
      applied_nxt = applied_r + 8'h01;
    end else if (step_bus.tick && applied_r > target) begin
      applied_nxt = applied_r - 8'h01;
    end
    busy_nxt = applied_nxt != target;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      applied_r <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      applied_r <= applied_nxt;
      busy_r <= busy_nxt;
    end
  end
  // ==========================================================================
  // Output decode
  // The enable, string and boost power pins are registered from the next ramp value, so they change on the same edge as the level.
  logic en_r;
  logic en_nxt;
  logic first_r;
  logic first_nxt;
  logic second_r;
  logic second_nxt;
  logic hv_r;
  logic hv_nxt;
  logic bpwr_r;
  logic bpwr_nxt;
  logic slow_r;
  logic slow_nxt;
  logic dfs_r;
  logic dfs_nxt;
  always_comb begin
    en_nxt = !ldc_is_boost(mode) && (applied_nxt != 8'h00);
    hv_nxt = 1'b0;
    bpwr_nxt = 1'b1;
    first_nxt = 1'b1;
    second_nxt = 1'b1;
    case (mode)
      ldc_pkg::LDC_MODE_BOTH: hv_nxt = 1'b0;
      ldc_pkg::LDC_MODE_FIRST: second_nxt = 1'b0;
      ldc_pkg::LDC_MODE_HV_BOOST: begin
        hv_nxt = 1'b1;
        first_nxt = 1'b0;
        second_nxt = 1'b0;
      end
      ldc_pkg::LDC_MODE_EXT_SUPPLY: bpwr_nxt = 1'b0;
      default: hv_nxt = 1'b0;
    endcase
    first_nxt = first_nxt & en_nxt;
    second_nxt = second_nxt & en_nxt;
    // The boost stage stays powered in boost mode even though no string is regulated.
    bpwr_nxt = bpwr_nxt & (en_nxt | hv_nxt);
    slow_nxt = config_r[ldc_pkg::LDC_CFG_SLOW_EDGE];
    dfs_nxt = config_r[ldc_pkg::LDC_CFG_DOUBLE_FS];
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_r <= 1'b0;
      hv_r <= 1'b0;
      bpwr_r <= 1'b0;
      first_r <= 1'b0;
      second_r <= 1'b0;
      slow_r <= ldc_pkg::LDC_CONFIG_RESET[ldc_pkg::LDC_CFG_SLOW_EDGE];
      dfs_r <= ldc_pkg::LDC_CONFIG_RESET[ldc_pkg::LDC_CFG_DOUBLE_FS];
    end else begin
      en_r <= en_nxt;
      hv_r <= hv_nxt;
      bpwr_r <= bpwr_nxt;
      first_r <= first_nxt;
      second_r <= second_nxt;
      slow_r <= slow_nxt;
      dfs_r <= dfs_nxt;
    end
  end
  // ==========================================================================
  // Outputs
  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;
  assign led_enable_out = en_r;
  assign first_string_out = first_r;
  assign second_string_out = second_r;
  assign hv_boost_out = hv_r;
  assign boost_power_out = bpwr_r;
  assign slow_edge_out = slow_r;
  assign double_full_scale_out = dfs_r;
  assign applied_level_out = applied_r;
  assign ramp_busy_out = busy_r;
endmodule // ldc_regs
`default_nettype wire

// ==== testbench/ldc_host.sv ====
// Host model that issues register strobes to the LED driver control block.
`default_nettype none
module ldc_host (
  input wire logic core_clk_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Strobe driver
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // Released address and data lines show the inverse so a stale value is never taken for a live one.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in) #1;
    wr_en_out = w;
    rd_en_out = !w;
    addr_out = a;
    wdata_out = d;
    @(posedge core_clk_in) #1;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule // ldc_host
`default_nettype wire

// ==== testbench/ldc_regs_sva.sv ====
// Checker of port timing for the LED driver control block.
`default_nettype none
module ldc_regs_sva (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic led_enable_out,
  input wire logic hv_boost_out,
  input wire logic double_full_scale_out,
  input wire logic [7:0] applied_level_out,
  input wire logic ramp_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Properties
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_step;
    $changed(applied_level_out);
  endsequence
  AST_RVALID: assert property (rd_en_in |=> rvalid_out) else $error("read answer missing");
  AST_BIT7: assert property (rd_en_in && addr_in == 8'h07 |=> !rdata_out[7]) else $error("bit 7 set");
  AST_UNMAP: assert property (rd_en_in && !(addr_in inside {8'h07, 8'h08}) |=> rdata_out == 8'h00)
    else $error("unmapped read data");
  AST_ONE_LSB: assert property (s_step |-> 8'(applied_level_out - $past(applied_level_out)) inside {8'h01, 8'hff})
    else $error("step not one lsb");
  AST_GAP: assert property (s_step |=> $stable(applied_level_out)) else $error("steps too close");
  AST_IDLE: assert property (!ramp_busy_out && !wr_en_in && !$past(wr_en_in) |=> $stable(applied_level_out))
    else $error("level moved while idle");
  AST_HV_OFF: assert property (hv_boost_out && $past(hv_boost_out) |-> !led_enable_out)
    else $error("led on in boost");
  AST_RST: assert property ($rose(rst_n_in) |-> double_full_scale_out && applied_level_out == 8'h00)
    else $error("bad reset state");
endmodule // ldc_regs_sva
bind ldc_regs ldc_regs_sva i_ldc_regs_sva (
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .addr_in(addr_in),
  .rdata_out(rdata_out),
  .rvalid_out(rvalid_out),
  .led_enable_out(led_enable_out),
  .hv_boost_out(hv_boost_out),
  .double_full_scale_out(double_full_scale_out),
  .applied_level_out(applied_level_out),
  .ramp_busy_out(ramp_busy_out)
);
`default_nettype wire

// ==== testbench/ldc_regs_tb_top.sv ====
// Self-checking bench for the LED driver control register bank.
`default_nettype none
module ldc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr_en, rd_en, rvalid, en, s1, s2, hv, bp, slow, dfs, busy;
  logic [7:0] addr, wdata, rdata, lvl, v;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  // ==========================================================================
  // Instances and tasks
  ldc_regs #(.STEP0_CYC(2), .STEP1_CYC(4)) i_ldc_regs (.core_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid),
    .led_enable_out(en), .first_string_out(s1), .second_string_out(s2), .hv_boost_out(hv), .boost_power_out(bp),
    .slow_edge_out(slow), .double_full_scale_out(dfs), .applied_level_out(lvl), .ramp_busy_out(busy));
  ldc_host i_ldc_host (.core_clk_in(clk), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_ldc_host.xfer(1'b0, a, 8'h00);
    chk(rvalid, 1'b1);
    chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clk) #1;
      n++;
    end
    chk(busy, 1'b0);
  endtask
  task automatic gap(input logic [7:0] code, input int exp);
    i_ldc_host.xfer(1'b1, 8'h07, code);
    i_ldc_host.xfer(1'b1, 8'h08, 8'h0a);
    @(lvl) #1;
    chk(busy, 1'b1);
    v = lvl;
    n = 0;
    while (lvl === v && n < 1000) begin
      @(posedge clk) #1;
      n++;
    end
    chk(n[15:0], exp[15:0]);
    i_ldc_host.xfer(1'b1, 8'h08, 8'h00);
    settle();
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang anywhere is cut short well past the longest expected run.
  initial begin
    #3_000_000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({dfs, slow}, 2'h2);
    rd(8'h07, 8'h0f);
    rd(8'h08, 8'h00);
    i_ldc_host.xfer(1'b1, 8'h07, 8'h90);
    rd(8'h07, 8'h10);
    chk({dfs, slow}, 2'h1);
    i_ldc_host.xfer(1'b1, 8'h08, 8'h03);
    settle();
    chk({en, lvl}, 9'h103);
    for (int m = 0; m < 4; m++) begin
      i_ldc_host.xfer(1'b1, 8'h07, 8'(m << 5));
      settle();
      v = (m == 2) ? 8'h00 : 8'h03;
      chk({hv, s1, s2, bp, en, lvl}, {m == 2, m != 2, m[0] == m[1], m != 3, m != 2, v});
    end
    i_ldc_host.xfer(1'b1, 8'h08, 8'h01);
    settle();
    chk(lvl, 8'h01);
    i_ldc_host.xfer(1'b1, 8'h08, 8'h00);
    settle();
    chk({en, lvl}, 9'h000);
    i_ldc_host.xfer(1'b1, 8'h09, 8'h55);
    rd(8'h09, 8'h00);
    rd(8'h08, 8'h00);
    gap(8'h00, 2);
    gap(8'h01, 4);
    gap(8'h07, 256);
    end_of_test();
  end
endmodule // ldc_regs_tb_top
`default_nettype wire
